// ### bench/rsq_ext_model.sv
// Reset line model: shared pull-up line and lagging filter
`timescale 1ns/1ps
`default_nettype none
module rsq_ext_model (
	// Clock
	input  wire logic       i_clk,
	// Line drivers
	input  wire logic       i_dut_oe,
	input  wire logic       i_ext_low,
	input  wire logic [3:0] i_dly,
	// Line levels
	output wire logic       o_pin,
	output wire logic       o_filt
);
	logic [15:0] hist = 16'hffff;
	// Pull-up wins when nobody drives
	assign o_pin = ~(i_dut_oe | i_ext_low);
	// Filter lag lets a released line still read low
	assign o_filt = (i_dly == 4'd0) ? o_pin : hist[i_dly - 4'd1];
	always @(posedge i_clk) begin
		hist <= {hist[14:0], o_pin};
	end
endmodule
`default_nettype wire

// ### bench/rsq_top_monitor.sv
// Port assertions for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rsq_top_monitor #(
	parameter SEQ_TCL = 11'd1024
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_reset_in_pin,
	input wire logic i_powerdown_reset_pin,
	input wire logic i_bus_uses_ready,
	input wire logic i_ready_n,
	input wire logic o_reset_in_pin_oe,
	input wire logic o_reset_out_pin_n,
	input wire logic o_powerdown_pulldown_en,
	input wire logic o_powerdown_pullup_en,
	input wire logic o_bus_abort,
	input wire logic o_core_reset
);
	logic [15:0] run_len;
	// Saturates so a stuck reset cannot wrap
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			run_len <= 16'h0;
		else if (!o_core_reset)
			run_len <= 16'h0;
		else if (run_len != 16'hffff)
			run_len <= run_len + 16'h1;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_pin_low;
		!i_reset_in_pin [*4];
	endsequence
	sequence s_oe_start;
		$rose(o_reset_in_pin_oe);
	endsequence
	property p_out_low; $rose(o_core_reset) |-> ##[0:2] !o_reset_out_pin_n; endproperty
	a_out_low: assert property (p_out_low) else $error("reset out high in reset");
	property p_out_rel; $rose(o_reset_out_pin_n) |-> !o_core_reset; endproperty
	a_out_rel: assert property (p_out_rel) else $error("reset out freed early");
	property p_pulldown; s_pin_low |-> ##[0:1] o_powerdown_pulldown_en; endproperty
	a_pulldown: assert property (p_pulldown) else $error("no pull-down");
	property p_oe_seq; o_reset_in_pin_oe |-> o_core_reset || $past(o_core_reset); endproperty
	a_oe_seq: assert property (p_oe_seq) else $error("pin driven outside reset");
	property p_oe_rpd; s_oe_start |-> $past(i_powerdown_reset_pin, 2); endproperty
	a_oe_rpd: assert property (p_oe_rpd) else $error("pin driven, powerdown low");
	property p_abort; o_bus_abort |-> i_bus_uses_ready && i_ready_n; endproperty
	a_abort: assert property (p_abort) else $error("bad bus abort");
	property p_pullup; $changed(o_powerdown_pullup_en) |-> $past(o_core_reset); endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up off sequence");
	property p_len; $fell(o_core_reset) |-> run_len >= SEQ_TCL; endproperty
	a_len: assert property (p_len) else $error("sequence too short");
endmodule
bind rsq_top rsq_top_monitor #(.SEQ_TCL(SEQ_TCL)) u_mon (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reset_in_pin(i_reset_in_pin),
	.i_powerdown_reset_pin(i_powerdown_reset_pin), .i_bus_uses_ready(i_bus_uses_ready),
	.i_ready_n(i_ready_n), .o_reset_in_pin_oe(o_reset_in_pin_oe),
	.o_reset_out_pin_n(o_reset_out_pin_n), .o_powerdown_pulldown_en(o_powerdown_pulldown_en),
	.o_powerdown_pullup_en(o_powerdown_pullup_en), .o_bus_abort(o_bus_abort),
	.o_core_reset(o_core_reset));
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam SEQ = 32;
	logic        i_clk = 0;
	logic        i_rst_n = 0;
	logic [3:0]  i_addr = 0;
	logic [15:0] i_wdata = 0;
	logic        i_wr = 0;
	logic        i_rd = 0;
	logic        powerdown_reset_pin = 1;
	logic        ext_low = 0;
	logic        bus = 0;
	logic        abort_seen = 0;
	logic [3:0]  dly = 1;
	logic [12:8] cfg = 5'h0a;
	logic [7:0]  rnd = 8'd88;
	logic [15:0] r;
	wire  [15:0] rdata;
	wire  [12:2] latched;
	wire         pin, filt, oe, rout_n, pdn, pup, abort, core, pout;
	integer      fail_count = 0;
	integer      num_checks = 0;
	integer      cyc = 0;
	rsq_top #(.SEQ_TCL(11'd32), .SAMPLE_TCL(11'd8), .SHORT_TCL(11'd4)) DUT (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_reset_in_pin(pin),
		.i_filtered_reset_in(filt), .i_powerdown_reset_pin(powerdown_reset_pin), .i_config_port(cfg),
		.o_reset_in_pin_out(pout), .o_reset_in_pin_oe(oe), .o_reset_out_pin_n(rout_n),
		.o_powerdown_pulldown_en(pdn), .o_powerdown_pullup_en(pup), .i_bus_active(bus),
		.i_bus_uses_ready(bus), .i_bus_wait_done(bus), .i_ready_n(bus),
		.o_bus_abort(abort), .o_core_reset(core), .o_config_latched(latched));
	rsq_ext_model ext (.i_clk(i_clk), .i_dut_oe(oe), .i_ext_low(ext_low),
		.i_dly(dly), .o_pin(pin), .o_filt(filt));
	always #12.5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc = cyc + 1;
		if (abort)
			abort_seen <= 1'b1;
		if (cyc == 90000) begin
			fail_count = fail_count + 1;
			report_and_stop;
		end
	end
	function [7:0] lfsr(input [7:0] x);
		lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	function [15:0] bitv(input integer b);
		bitv = 16'h1 << b;
	endfunction
	task chk(input [15:0] got, input [15:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input [3:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		r = rdata;
	endtask
	// Bounded wait on the core reset level
	task wait_core(input v, input integer lim);
		integer n;
		n = 0;
		while (core !== v && n < lim) begin
			@(posedge i_clk);
			n = n + 1;
		end
		chk({15'h0, core}, {15'h0, v});
		repeat (4) @(posedge i_clk);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		chk({15'h0, rout_n}, 16'h0);
		wait_core(1'b0, 300);
		rd(4'h1);
		chk(r & bitv(7), bitv(7));
		wr(4'h0, 16'h0018);
		wr(4'h1, bitv(1));
		wr(4'h0, 16'h0000);
		rd(4'h0);
		chk(r & 16'h0018, 16'h0018);
		chk({15'h0, rout_n}, 16'h1);
		dly <= 4'd0;
		wr(4'h1, bitv(2));
		wait_core(1'b1, 20);
		chk({15'h0, rout_n}, 16'h0);
		wait_core(1'b0, 300);
		$display("init test done");
		for (int i = 0; i < 2; i++) begin
			rnd = lfsr(rnd);
			cfg <= rnd[4:0];
			dly <= 4'd0;
			wr(4'h0, 16'h0018);
			wr(4'h1, bitv(2));
			wait_core(1'b1, 20);
			chk({14'h0, oe, rout_n}, 16'h2);
			chk({15'h0, pout}, 16'h0);
			wait_core(1'b0, 300);
			rd(4'h1);
			chk(r & 16'h0078, bitv(4));
			chk({5'h0, latched}, {5'h0, cfg, 6'h3f});
			chk({15'h0, pup}, 16'h1);
			rd(4'h0);
			chk(r & 16'h0008, 16'h0);
		end
		$display("sw reset test done");
		wr(4'h0, 16'h0008);
		dly <= 4'd12;
		wr(4'h1, bitv(2));
		wait_core(1'b1, 20);
		repeat (SEQ * 4) @(posedge i_clk);
		wait_core(1'b0, 300);
		rd(4'h1);
		chk(r & 16'h0028, bitv(5));
		$display("degeneration test done");
		dly <= 4'd1;
		ext_low <= 1'b1;
		repeat (10) @(posedge i_clk);
		chk({15'h0, pdn}, 16'h1);
		ext_low <= 1'b0;
		repeat (SEQ * 2) @(posedge i_clk);
		wait_core(1'b0, 300);
		rd(4'h1);
		chk(r & 16'h0060, bitv(5));
		ext_low <= 1'b1;
		repeat (SEQ + 30) @(posedge i_clk);
		ext_low <= 1'b0;
		wait_core(1'b0, 300);
		rd(4'h1);
		chk(r & 16'h0060, 16'h0060);
		$display("hw reset test done");
		wr(4'h0, 16'h0008);
		powerdown_reset_pin <= 1'b0;
		bus <= 1'b1;
		wait_core(1'b1, 70000);
		chk({15'h0, oe}, 16'h0);
		wait_core(1'b0, 300);
		powerdown_reset_pin <= 1'b1;
		rd(4'h1);
		chk(r & 16'h0008, 16'h0008);
		chk({15'h0, abort_seen}, 16'h1);
		$display("watchdog test done");
		report_and_stop;
	end
endmodule
`default_nettype wire

// ### rtl/rsq_defines.vh
// Constants for the reset sequencer
`ifndef RSQ_DEFINES_VH
`define RSQ_DEFINES_VH

// Sequence lengths in clock_time_unit periods
`define RSQ_SEQ_TCL      11'd1024
`define RSQ_SAMPLE_TCL   11'd8
`define RSQ_SHORT_TCL    11'd4
`define RSQ_CNT_W        11

// Register offsets
`define RSQ_ADDR_SYSCFG  4'h0
`define RSQ_ADDR_WDCTL   4'h1
`define RSQ_ADDR_CFGPORT 4'h2
`define RSQ_ADDR_STATUS  4'h3

// system_config_reg fields
`define RSQ_BIT_BIDIR    3
`define RSQ_BIT_POWERDOWN_PULLUP_CFG   4
`define RSQ_BIT_WDDIS    0

// wdog_control_reg fields
`define RSQ_BIT_SERVICE  0
`define RSQ_BIT_END_OF_INIT_INSTR    1
`define RSQ_BIT_SWRST    2
`define RSQ_FLAG_WDTR    3
`define RSQ_FLAG_SWR     4
`define RSQ_FLAG_SHWR    5
`define RSQ_FLAG_LHWR    6
`define RSQ_FLAG_PONR    7

// Config port fields
`define RSQ_CFG_LATCH_HI 12
`define RSQ_CFG_LATCH_LO 8
`define RSQ_CFG_SET_HI   7
`define RSQ_CFG_SET_LO   2
`define RSQ_CFG_ONES     6'h3f

`define RSQ_WD_RELOAD    16'h0000
`define RSQ_WD_MAX       16'hffff

`endif

// ### rtl/rsq_sync.v
// Two-stage synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none

module rsq_sync #(
	parameter RESET_VAL = 1'b1
) (
	// Clock and reset
	input  wire i_clk,
	input  wire i_rst_n,
	// Level
	input  wire i_d,
	output reg  o_q
);

	reg meta;

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= RESET_VAL;
			o_q  <= RESET_VAL;
		end else begin
			meta <= i_d;
			o_q  <= meta;
		end
	end

endmodule
`default_nettype wire

// ### rtl/rsq_top.v
// Watchdog and bidirectional reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rsq_defines.vh"

module rsq_top #(
	parameter SEQ_TCL    = `RSQ_SEQ_TCL,
	parameter SAMPLE_TCL = `RSQ_SAMPLE_TCL,
	parameter SHORT_TCL  = `RSQ_SHORT_TCL
) (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst_n,
	// Register port
	input  wire [3:0]  i_addr,
	input  wire [15:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [15:0] o_rdata,
	// Pins
	input  wire        i_reset_in_pin,
	input  wire        i_filtered_reset_in,
	input  wire        i_powerdown_reset_pin,
	input  wire [12:8] i_config_port,
	output reg         o_reset_in_pin_out,
	output reg         o_reset_in_pin_oe,
	output reg         o_reset_out_pin_n,
	output reg         o_powerdown_pulldown_en,
	output reg         o_powerdown_pullup_en,
	// External bus
	input  wire        i_bus_active,
	input  wire        i_bus_uses_ready,
	input  wire        i_bus_wait_done,
	input  wire        i_ready_n,
	output reg         o_bus_abort,
	// Core
	output reg         o_core_reset,
	output reg  [12:2] o_config_latched
);

	localparam ST_RUN   = 3'd0;
	localparam ST_BUSW  = 3'd1;
	localparam ST_SEQ   = 3'd2;
	localparam ST_SAMP  = 3'd3;
	localparam ST_WATCH = 3'd4;
	localparam ST_ASYNC = 3'd5;

	localparam K_HW  = 2'd0;
	localparam K_SW  = 2'd1;
	localparam K_WD  = 2'd2;

	////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers

	reg  rst_m;
	reg  rst_s;
	wire pin_s;
	wire filt_s;
	wire pd_s;
	wire rdy_s;

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_m <= 1'b0;
			rst_s <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_s <= rst_m;
		end
	end

	rsq_sync #(.RESET_VAL(1'b1)) u_pin (
		.i_clk(i_clk), .i_rst_n(rst_s), .i_d(i_reset_in_pin), .o_q(pin_s));
	rsq_sync #(.RESET_VAL(1'b1)) u_filt (
		.i_clk(i_clk), .i_rst_n(rst_s), .i_d(i_filtered_reset_in), .o_q(filt_s));
	rsq_sync #(.RESET_VAL(1'b0)) u_pd (
		.i_clk(i_clk), .i_rst_n(rst_s), .i_d(i_powerdown_reset_pin), .o_q(pd_s));
	rsq_sync #(.RESET_VAL(1'b1)) u_rdy (
		.i_clk(i_clk), .i_rst_n(rst_s), .i_d(i_ready_n), .o_q(rdy_s));

	////////////////////////////////////////////////////////////////////////////
	// Config port synchronisers

	// Pins may move near the latch edge; sync guards against metastability
	wire [12:8] cfg_s;
	genvar      gi;
	generate
		for (gi = `RSQ_CFG_LATCH_LO; gi <= `RSQ_CFG_LATCH_HI; gi = gi + 1) begin : g_cfg
			rsq_sync #(.RESET_VAL(1'b1)) u_cfg (
				.i_clk(i_clk), .i_rst_n(rst_s), .i_d(i_config_port[gi]), .o_q(cfg_s[gi]));
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// State

	reg [2:0]              state;
	reg [1:0]              kind;
	reg [`RSQ_CNT_W-1:0]   cnt;
	reg                    drive_low;
	reg                    bidir;
	reg                    powerdown_pullup_cfg;
	reg                    wd_dis;
	reg                    end_of_init_instr_done;
	reg [15:0]             wdog;
	reg                    f_wdtr;
	reg                    f_swr;
	reg                    f_shwr;
	reg                    f_lhwr;
	reg                    f_ponr;
	reg                    pon_pending;
	reg [4:0]              hold_cnt;

	wire wr_sys  = i_wr && (i_addr == `RSQ_ADDR_SYSCFG);
	wire wr_wd   = i_wr && (i_addr == `RSQ_ADDR_WDCTL);
	wire service = wr_wd && i_wdata[`RSQ_BIT_SERVICE];
	wire end_of_init_instr   = wr_wd && i_wdata[`RSQ_BIT_END_OF_INIT_INSTR];
	wire swrst   = wr_wd && i_wdata[`RSQ_BIT_SWRST];
	wire wd_ovf  = !wd_dis && (wdog == `RSQ_WD_MAX) && !service;
	// Hardware request; sampled pin, so minimum pulse is a few cycles
	wire hw_req  = !pin_s && !drive_low;
	wire async_req = !pin_s && !pd_s;
	wire bus_can_end = !i_bus_uses_ready || !rdy_s;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always @(posedge i_clk or negedge rst_s) begin
		if (!rst_s) begin
			state       <= ST_SEQ;
			kind        <= K_HW;
			cnt         <= {`RSQ_CNT_W{1'b0}};
			drive_low   <= 1'b0;
			bidir       <= 1'b0;
			powerdown_pullup_cfg      <= 1'b0;
			wd_dis      <= 1'b0;
			end_of_init_instr_done  <= 1'b0;
			wdog        <= `RSQ_WD_RELOAD;
			f_wdtr      <= 1'b0;
			f_swr       <= 1'b0;
			f_shwr      <= 1'b0;
			f_lhwr      <= 1'b0;
			f_ponr      <= 1'b0;
			pon_pending <= 1'b1;
			hold_cnt    <= 5'h00;
			o_bus_abort <= 1'b0;
			o_core_reset <= 1'b1;
			o_reset_out_pin_n <= 1'b0;
			o_config_latched  <= 11'h7ff;
			o_powerdown_pullup_en <= 1'b0;
		end else begin
			o_bus_abort <= 1'b0;
			if (state == ST_RUN) begin
				if (wr_sys && !end_of_init_instr_done) begin
					bidir  <= i_wdata[`RSQ_BIT_BIDIR];
					powerdown_pullup_cfg <= i_wdata[`RSQ_BIT_POWERDOWN_PULLUP_CFG];
					wd_dis <= i_wdata[`RSQ_BIT_WDDIS];
				end
				if (end_of_init_instr) begin
					end_of_init_instr_done        <= 1'b1;
					o_reset_out_pin_n <= 1'b1;
				end
				wdog <= service ? `RSQ_WD_RELOAD : wdog + 16'h0001;
			end
			case (state)
			ST_RUN: begin
				if (async_req) begin
					state <= ST_ASYNC;
				end else if (hw_req || swrst || wd_ovf) begin
					kind <= hw_req ? K_HW : (swrst ? K_SW : K_WD);
					// Watchdog waits for bus; hw and sw reset at once
					if (wd_ovf && !hw_req && !swrst && i_bus_active) begin
						state <= ST_BUSW;
					end else begin
						state <= ST_SEQ;
						cnt <= {`RSQ_CNT_W{1'b0}};
						o_core_reset <= 1'b1;
						o_reset_out_pin_n <= 1'b0;
						bidir <= 1'b0;
						// bidir drive on hw request; for sw and wdog only with powerdown pin high
						drive_low <= bidir && (hw_req || pd_s);
					end
				end
			end
			ST_BUSW: begin
				if (!i_bus_active || (i_bus_wait_done && bus_can_end)) begin
					state <= ST_SEQ;
				end else if (i_bus_wait_done) begin
					o_bus_abort <= 1'b1;
					state <= ST_SEQ;
				end
				if (!i_bus_active || i_bus_wait_done) begin
					cnt <= {`RSQ_CNT_W{1'b0}};
					o_core_reset <= 1'b1;
					o_reset_out_pin_n <= 1'b0;
					drive_low <= bidir && pd_s;
					bidir <= 1'b0;
				end
			end
			ST_SEQ: begin
				cnt <= cnt + 1'b1;
				if (kind != K_HW && !pd_s) begin
					drive_low <= 1'b0;
				end
				if (kind == K_HW && async_req) begin
					state <= ST_ASYNC;
				end else if (cnt == SEQ_TCL - 1'b1) begin
					drive_low <= 1'b0;
					cnt <= {`RSQ_CNT_W{1'b0}};
					o_powerdown_pullup_en <= powerdown_pullup_cfg;
					if (kind == K_HW) begin
						state <= ST_SAMP;
					end else begin
						// sw and wdog keep bits 12..8 fresh, 7..2 forced high
						o_config_latched[`RSQ_CFG_LATCH_HI:`RSQ_CFG_LATCH_LO]
							<= cfg_s;
						o_config_latched[`RSQ_CFG_SET_HI:`RSQ_CFG_SET_LO]
							<= `RSQ_CFG_ONES;
						f_wdtr <= (kind == K_WD);
						f_swr  <= (kind == K_SW);
						f_shwr <= 1'b0;
						f_lhwr <= 1'b0;
						f_ponr <= 1'b0;
						o_core_reset <= 1'b0;
						hold_cnt <= 5'h00;
						state <= ST_WATCH;
					end
				end
			end
			ST_SAMP: begin
				// Saturate so a long reset cannot wrap into a second sample
				if (cnt != {`RSQ_CNT_W{1'b1}}) begin
					cnt <= cnt + 1'b1;
				end
				if (cnt == SAMPLE_TCL - 1'b1) begin
					f_shwr <= 1'b1;
					f_lhwr <= !filt_s;
					f_swr  <= 1'b1;
					f_wdtr <= 1'b0;
					f_ponr <= pon_pending;
					pon_pending <= 1'b0;
					o_config_latched <= {cfg_s, `RSQ_CFG_ONES};
					if (filt_s) begin
						o_core_reset <= 1'b0;
						end_of_init_instr_done <= 1'b0;
						state <= ST_RUN;
					end
				end else if (cnt > SAMPLE_TCL - 1'b1 && filt_s) begin
					// Long reset lasts until filtered input rises
					o_core_reset <= 1'b0;
					end_of_init_instr_done <= 1'b0;
					state <= ST_RUN;
				end
			end
			ST_WATCH: begin
				end_of_init_instr_done <= 1'b0;
				wdog <= `RSQ_WD_RELOAD;
				// Own release and sync lag count toward the low time
				hold_cnt <= filt_s ? 5'h00 : hold_cnt + 5'h01;
				if (!filt_s && hold_cnt == SHORT_TCL - 1'b1) begin
					kind <= K_HW;
					cnt <= {`RSQ_CNT_W{1'b0}};
					o_core_reset <= 1'b1;
					o_reset_out_pin_n <= 1'b0;
					state <= ST_SEQ;
				end else if (filt_s || hold_cnt == SAMPLE_TCL[4:0]) begin
					state <= ST_RUN;
				end
			end
			ST_ASYNC: begin
				o_core_reset <= 1'b1;
				o_reset_out_pin_n <= 1'b0;
				drive_low <= bidir;
				bidir <= 1'b0;
				f_lhwr <= 1'b1;
				f_shwr <= 1'b1;
				f_swr  <= 1'b1;
				f_wdtr <= 1'b0;
				if (pin_s) begin
					cnt <= {`RSQ_CNT_W{1'b0}};
					kind <= K_HW;
					state <= ST_SEQ;
				end
			end
			default: state <= ST_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin drivers and read port

	always @(posedge i_clk or negedge rst_s) begin
		if (!rst_s) begin
			o_reset_in_pin_out      <= 1'b0;
			o_reset_in_pin_oe       <= 1'b0;
			o_powerdown_pulldown_en <= 1'b0;
			o_rdata                 <= 16'h0000;
		end else begin
			// Open drain: level fixed low, only the enable moves
			o_reset_in_pin_out      <= 1'b0;
			o_reset_in_pin_oe       <= drive_low;
			o_powerdown_pulldown_en <= !pin_s;
			o_rdata <= 16'h0000;
			if (i_rd) begin
				if (i_addr == `RSQ_ADDR_SYSCFG) begin
					o_rdata <= {11'h000, powerdown_pullup_cfg, bidir, 2'b00, wd_dis};
				end else if (i_addr == `RSQ_ADDR_WDCTL) begin
					o_rdata <= {8'h00, f_ponr, f_lhwr, f_shwr, f_swr, f_wdtr,
						3'b000};
				end else if (i_addr == `RSQ_ADDR_CFGPORT) begin
					o_rdata <= {3'b000, o_config_latched, 2'b00};
				end else if (i_addr == `RSQ_ADDR_STATUS) begin
					o_rdata <= {10'h000, end_of_init_instr_done, drive_low, 1'b0, state};
				end
			end
		end
	end

endmodule
`default_nettype wire
